// File: pkg/smdb_pkg.sv
// constants for the monitoring data sector builder
package smdb_pkg;

  // sector geometry
  localparam logic [9:0] SECTOR_BYTES = 10'h200;
  localparam logic [9:0] LAST_BYTE    = 10'h1ff;
  localparam logic [9:0] ENTRY_FIRST  = 10'h002;
  localparam logic [9:0] ENTRY_END    = 10'h16a;
  localparam logic [3:0] ENTRY_BYTES  = 4'hc;
  localparam int         ENTRY_COUNT  = 30;

  // sector kinds
  typedef enum logic [1:0] {
    SMDB_SEC_VALUES = 2'h0,
    SMDB_SEC_THRESH = 2'h1,
    SMDB_SEC_LOGDIR = 2'h2,
    SMDB_SEC_ERRLOG = 2'h3
  } smdb_sector_t;

  // attribute-values sector tail offsets
  localparam logic [9:0] OFF_OFFLINE_STATUS = 10'h16a;
  localparam logic [9:0] OFF_SELFTEST_STAT  = 10'h16b;
  localparam logic [9:0] OFF_COLLECT_LO     = 10'h16c;
  localparam logic [9:0] OFF_COLLECT_HI     = 10'h16d;
  localparam logic [9:0] OFF_OFFLINE_CAP    = 10'h16f;
  localparam logic [9:0] OFF_SMART_CAP_LO   = 10'h170;
  localparam logic [9:0] OFF_SMART_CAP_HI   = 10'h171;
  localparam logic [9:0] OFF_ERRLOG_CAP     = 10'h172;
  localparam logic [9:0] OFF_CHECKPOINT     = 10'h173;
  localparam logic [9:0] OFF_SHORT_TIME     = 10'h174;
  localparam logic [9:0] OFF_EXT_TIME_BYTE  = 10'h175;
  localparam logic [9:0] OFF_EXT_TIME_LO    = 10'h177;
  localparam logic [9:0] OFF_EXT_TIME_HI    = 10'h178;

  // revision word shared by values and thresholds sectors
  localparam logic [15:0] SECTOR_REVISION = 16'h0010;

  // off-line capability bit positions and settings
  localparam int CAP_IMMEDIATE = 0;
  localparam int CAP_AUTO_OFF  = 1;
  localparam int CAP_ABORT     = 2;
  localparam int CAP_SCAN      = 3;
  localparam int CAP_SELFTEST  = 4;
  localparam int CAP_SELECTIVE = 6;
  localparam logic HAS_IMMEDIATE = 1'b1;
  localparam logic HAS_AUTO_OFF  = 1'b1;
  localparam logic ABORTS_ON_CMD = 1'b0;
  localparam logic HAS_SCAN      = 1'b1;
  localparam logic HAS_SELFTEST  = 1'b1;
  localparam logic HAS_SELECTIVE = 1'b0;

  // capability word and error logging byte
  localparam logic [15:0] SMART_CAP_WORD = 16'h0003;
  localparam logic [7:0]  ERRLOG_CAP     = 8'h01;
  localparam logic [7:0]  EXT_TIME_ESC   = 8'hff;

  // log directory
  localparam logic [15:0] LOG_VERSION      = 16'h0001;
  localparam logic [7:0]  LOG_VENDOR_FIRST = 8'h80;
  localparam logic [7:0]  LOG_VENDOR_LAST  = 8'h9f;
  localparam logic [7:0]  LOG_VENDOR_LEN   = 8'h10;
  localparam logic [7:0]  LOG_ERRLOG_ADDR  = 8'h01;
  localparam logic [7:0]  LOG_ERRLOG_LEN   = 8'h01;

  // summary error log
  localparam logic [7:0]  ERRLOG_VERSION = 8'h01;
  localparam logic [9:0]  OFF_ERRCNT_LO  = 10'h1c4;
  localparam logic [9:0]  OFF_ERRCNT_HI  = 10'h1c5;
  localparam logic [2:0]  ERR_INDEX_MIN  = 3'h1;
  localparam logic [2:0]  ERR_INDEX_MAX  = 3'h5;
  localparam logic [15:0] ERR_COUNT_MAX  = 16'hffff;

  // attribute table, fixed at manufacture
  localparam logic [15:0] ATTR_FLAGS = 16'h0002;
  localparam logic [7:0] ATTR_ID [ENTRY_COUNT] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c,
    8'h16, 8'hc0, 8'hc1, 8'hc2, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ATTR_THRESH [ENTRY_COUNT] = '{
    8'h10, 8'h10, 8'h10, 8'h00, 8'h10, 8'h10, 8'h10, 8'h00, 8'h10, 8'h00,
    8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // register port map (word addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_OFF_STAT  = 8'h01;
  localparam logic [7:0] REG_ST_STAT   = 8'h02;
  localparam logic [7:0] REG_COLLECT   = 8'h03;
  localparam logic [7:0] REG_CHECKPT   = 8'h04;
  localparam logic [7:0] REG_SHORT_T   = 8'h05;
  localparam logic [7:0] REG_EXT_T     = 8'h06;
  localparam logic [7:0] REG_ERR_CNT   = 8'h07;
  localparam logic [7:0] REG_ERR_IDX   = 8'h08;
  localparam logic [7:0] REG_VAL_BASE  = 8'h40;
  localparam int         CTRL_START    = 4;
  localparam int         CTRL_BUSY     = 8;

endpackage

// File: rtl/smdb_sector_builder.sv
// monitoring data sector builder: register port and byte stream out
// Operation
// [R1] collection-time field reports seconds to finish
// [R2] capability bit0: immediate off-line implemented
// [R3] capability bit1: auto off-line control implemented
// [R4] capability bit2: suspend (0) or abort (1)
// [R5] capability bit3: off-line read scanning supported
// [R6] capability bit4: self-test routine implemented
// [R7] bit6 selective self-test; bits 5,7 zero
// [R8] capability word 03h; bit0 saves before standby
// [R9] word bit1 autosave command; bits 2-15 zero
// [R10] error-logging byte bit0 set, rest zero
// [R11] last byte: two's complement of sum
// [R12] multi-byte fields emitted little-endian
// [R13] thresholds sector layout, zero reserved, checksum
// [R14] thresholds revision equals values revision 0010h
// [R15] threshold entries match attribute order and ids
// [R16] entry: id, threshold, ten zero bytes
// [R17] thresholds fixed constants, never host-writable
// [R18] directory version 01h, count plus reserved
// [R19] logs 80h-9Fh reported 16 sectors long
// [R20] error log: version, index, records, count
// [R21] index points newest record, values 1-5
// [R22] error count totals errors, never wraps
// [R23] error counter saturates at ffffh
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module smdb_sector_builder (
  input  wire logic        i_clk,        // 20 MHz system clock
  input  wire logic        i_arst_n,     // async reset, active low
  input  wire logic [7:0]  i_addr,       // register word address
  input  wire logic [15:0] i_wdata,      // register write data
  input  wire logic        i_wr,         // write strobe
  input  wire logic        i_rd,         // read strobe
  output logic      [15:0] o_rdata,      // read data, cycle after i_rd
  input  wire logic        i_error,      // one logged error per cycle held high
  output logic      [7:0]  o_data,       // sector byte
  output logic             o_valid,      // sector byte valid
  output logic             o_last,       // final byte of sector
  input  wire logic        i_ready,      // consumer takes byte
  output logic             o_busy        // sector transfer running
);

  typedef enum logic {SMDB_IDLE, SMDB_RUN} smdb_state_t;

  smdb_state_t                 state;
  smdb_pkg::smdb_sector_t      sector;
  logic [9:0]                  ptr;
  logic [7:0]                  sum;
  logic [7:0]                  offline_status;
  logic [7:0]                  selftest_status;
  logic [15:0]                 collect_time;
  logic [7:0]                  checkpoint;
  logic [7:0]                  short_time;
  logic [15:0]                 ext_time;
  logic [15:0]                 err_count;
  logic [2:0]                  err_index;
  logic [7:0]                  attr_value [smdb_pkg::ENTRY_COUNT];
  logic [7:0]                  cur_byte;

  // register decode
  wire       wr_ctrl   = i_wr && (i_addr == smdb_pkg::REG_CTRL);
  wire       start     = wr_ctrl && i_wdata[smdb_pkg::CTRL_START]
                         && (state == SMDB_IDLE);
  wire [7:0] val_rel   = i_addr - smdb_pkg::REG_VAL_BASE;
  wire       val_hit   = (i_addr >= smdb_pkg::REG_VAL_BASE) &&
                         (val_rel < 8'(smdb_pkg::ENTRY_COUNT));
  wire [4:0] val_idx   = val_rel[4:0];

  // stream handshake
  wire       more      = (ptr < smdb_pkg::SECTOR_BYTES);
  wire       slot_free = !o_valid || i_ready;
  wire       load      = (state == SMDB_RUN) && slot_free && more;
  wire       finish    = (state == SMDB_RUN) && slot_free && !more;

  // entry region position
  wire       in_entry  = (ptr >= smdb_pkg::ENTRY_FIRST) &&
                         (ptr < smdb_pkg::ENTRY_END);
  wire [9:0] ent_rel   = ptr - smdb_pkg::ENTRY_FIRST;
  wire [4:0] ent_idx   = 5'(ent_rel / 10'(smdb_pkg::ENTRY_BYTES));
  wire [3:0] ent_pos   = 4'(ent_rel % 10'(smdb_pkg::ENTRY_BYTES));
  wire [4:0] ent_sel   = in_entry ? ent_idx : 5'h00;

  // directory position: one count byte and one reserved byte per log
  wire [7:0] log_addr  = ptr[8:1];
  wire       log_odd   = ptr[0];
  wire       log_vend  = (log_addr >= smdb_pkg::LOG_VENDOR_FIRST) &&
                         (log_addr <= smdb_pkg::LOG_VENDOR_LAST);

  // capability byte assembled bit by bit
  wire [7:0] offline_cap = {
    1'b0,                                 // R7
    smdb_pkg::HAS_SELECTIVE,              // R7
    1'b0,                                 // R7
    smdb_pkg::HAS_SELFTEST,               // R6
    smdb_pkg::HAS_SCAN,                   // R5
    smdb_pkg::ABORTS_ON_CMD,              // R4
    smdb_pkg::HAS_AUTO_OFF,               // R3
    smdb_pkg::HAS_IMMEDIATE};             // R2

  wire [7:0] ext_byte  = (ext_time > 16'(smdb_pkg::EXT_TIME_ESC - 8'h01))
                         ? smdb_pkg::EXT_TIME_ESC : ext_time[7:0];
  wire [7:0] check     = 8'(~sum + 8'h01);

  // byte at the current offset of the selected sector
  always_comb begin
    cur_byte = 8'h00;
    case (sector)
      smdb_pkg::SMDB_SEC_VALUES: begin
        if (ptr == smdb_pkg::LAST_BYTE) begin
          cur_byte = check;                                   // R11
        end else if (ptr < smdb_pkg::ENTRY_FIRST) begin
          cur_byte = ptr[0] ? smdb_pkg::SECTOR_REVISION[15:8]
                            : smdb_pkg::SECTOR_REVISION[7:0];  // R12
        end else if (in_entry) begin
          case (ent_pos)
            4'h0:    cur_byte = smdb_pkg::ATTR_ID[ent_sel];
            4'h1:    cur_byte = smdb_pkg::ATTR_FLAGS[7:0];
            4'h2:    cur_byte = smdb_pkg::ATTR_FLAGS[15:8];
            4'h3:    cur_byte = attr_value[ent_sel];
            default: cur_byte = 8'h00;
          endcase
        end else begin
          case (ptr)
            smdb_pkg::OFF_OFFLINE_STATUS: cur_byte = offline_status;
            smdb_pkg::OFF_SELFTEST_STAT:  cur_byte = selftest_status;
            smdb_pkg::OFF_COLLECT_LO:     cur_byte = collect_time[7:0];  // R1
            smdb_pkg::OFF_COLLECT_HI:     cur_byte = collect_time[15:8]; // R1
            smdb_pkg::OFF_OFFLINE_CAP:    cur_byte = offline_cap;
            smdb_pkg::OFF_SMART_CAP_LO:
              cur_byte = smdb_pkg::SMART_CAP_WORD[7:0];       // R8
            smdb_pkg::OFF_SMART_CAP_HI:
              cur_byte = smdb_pkg::SMART_CAP_WORD[15:8];      // R9
            smdb_pkg::OFF_ERRLOG_CAP:     cur_byte = smdb_pkg::ERRLOG_CAP; // R10
            smdb_pkg::OFF_CHECKPOINT:     cur_byte = checkpoint;
            smdb_pkg::OFF_SHORT_TIME:     cur_byte = short_time;
            smdb_pkg::OFF_EXT_TIME_BYTE:  cur_byte = ext_byte;
            smdb_pkg::OFF_EXT_TIME_LO:    cur_byte = ext_time[7:0];
            smdb_pkg::OFF_EXT_TIME_HI:    cur_byte = ext_time[15:8];
            default:                      cur_byte = 8'h00;
          endcase
        end
      end
      smdb_pkg::SMDB_SEC_THRESH: begin
        if (ptr == smdb_pkg::LAST_BYTE) begin
          cur_byte = check;                                   // R11 R13
        end else if (ptr < smdb_pkg::ENTRY_FIRST) begin
          cur_byte = ptr[0] ? smdb_pkg::SECTOR_REVISION[15:8]
                            : smdb_pkg::SECTOR_REVISION[7:0];  // R12 R14
        end else if (in_entry) begin
          case (ent_pos)
            4'h0:    cur_byte = smdb_pkg::ATTR_ID[ent_sel];     // R15 R16
            4'h1:    cur_byte = smdb_pkg::ATTR_THRESH[ent_sel]; // R16 R17
            default: cur_byte = 8'h00;                          // R16
          endcase
        end else begin
          cur_byte = 8'h00;                                   // R13
        end
      end
      smdb_pkg::SMDB_SEC_LOGDIR: begin
        if (ptr < smdb_pkg::ENTRY_FIRST) begin
          cur_byte = ptr[0] ? smdb_pkg::LOG_VERSION[15:8]
                            : smdb_pkg::LOG_VERSION[7:0];     // R18
        end else if (log_odd) begin
          cur_byte = 8'h00;                                   // R18
        end else if (log_vend) begin
          cur_byte = smdb_pkg::LOG_VENDOR_LEN;                // R19
        end else if (log_addr == smdb_pkg::LOG_ERRLOG_ADDR) begin
          cur_byte = smdb_pkg::LOG_ERRLOG_LEN;
        end else begin
          cur_byte = 8'h00;
        end
      end
      smdb_pkg::SMDB_SEC_ERRLOG: begin
        case (ptr)
          10'h000:                 cur_byte = smdb_pkg::ERRLOG_VERSION; // R20
          10'h001:                 cur_byte = {5'h00, err_index};       // R21
          smdb_pkg::OFF_ERRCNT_LO: cur_byte = err_count[7:0];     // R12 R20
          smdb_pkg::OFF_ERRCNT_HI: cur_byte = err_count[15:8];    // R12 R20
          smdb_pkg::LAST_BYTE:     cur_byte = check;              // R11
          default:                 cur_byte = 8'h00;
        endcase
      end
      default: cur_byte = 8'h00;
    endcase
  end

  // transfer sequencing
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state  <= SMDB_IDLE;
      sector <= smdb_pkg::SMDB_SEC_VALUES;
      ptr    <= 10'h000;
    end else if (start) begin
      state  <= SMDB_RUN;
      sector <= smdb_pkg::smdb_sector_t'(i_wdata[1:0]);
      ptr    <= 10'h000;
    end else if (load) begin
      ptr    <= ptr + 10'h001;
    end else if (finish) begin
      state  <= SMDB_IDLE;
    end
  end

  // output byte stage and running sum
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data  <= 8'h00;
      o_valid <= 1'b0;
      o_last  <= 1'b0;
      sum     <= 8'h00;
    end else if (start) begin
      sum     <= 8'h00;
    end else if (load) begin
      o_data  <= cur_byte;
      o_valid <= 1'b1;
      o_last  <= (ptr == smdb_pkg::LAST_BYTE);
      sum     <= sum + cur_byte;                              // R11
    end else if (i_ready) begin
      o_valid <= 1'b0;
      o_last  <= 1'b0;
    end
  end

  // host-visible status fields; thresholds have no write path
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      offline_status  <= 8'h00;
      selftest_status <= 8'h00;
      collect_time    <= 16'h0000;
      checkpoint      <= 8'h00;
      short_time      <= 8'h00;
      ext_time        <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        smdb_pkg::REG_OFF_STAT: offline_status  <= i_wdata[7:0];
        smdb_pkg::REG_ST_STAT:  selftest_status <= i_wdata[7:0];
        smdb_pkg::REG_COLLECT:  collect_time    <= i_wdata;    // R1
        smdb_pkg::REG_CHECKPT:  checkpoint      <= i_wdata[7:0];
        smdb_pkg::REG_SHORT_T:  short_time      <= i_wdata[7:0];
        smdb_pkg::REG_EXT_T:    ext_time        <= i_wdata;
        default: ;
      endcase
    end
  end

  // attribute values written by firmware
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < smdb_pkg::ENTRY_COUNT; k++) begin
        attr_value[k] <= 8'h00;
      end
    end else if (i_wr && val_hit) begin
      attr_value[val_idx] <= i_wdata[7:0];
    end
  end

  // error tally and newest-record pointer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_count <= 16'h0000;
      err_index <= smdb_pkg::ERR_INDEX_MAX;
    end else if (i_error) begin
      if (err_count != smdb_pkg::ERR_COUNT_MAX) begin
        err_count <= err_count + 16'h0001;                    // R22 R23
      end
      err_index <= (err_index == smdb_pkg::ERR_INDEX_MAX)
                   ? smdb_pkg::ERR_INDEX_MIN
                   : err_index + 3'h1;                         // R21
    end
  end

  // read data, valid only in the cycle after the strobe
  logic [15:0] rd_mux;
  assign rd_mux =
    (i_addr == smdb_pkg::REG_CTRL)     ? {7'h00, (state == SMDB_RUN),
                                          6'h00, sector} :
    (i_addr == smdb_pkg::REG_OFF_STAT) ? {8'h00, offline_status} :
    (i_addr == smdb_pkg::REG_ST_STAT)  ? {8'h00, selftest_status} :
    (i_addr == smdb_pkg::REG_COLLECT)  ? collect_time :
    (i_addr == smdb_pkg::REG_CHECKPT)  ? {8'h00, checkpoint} :
    (i_addr == smdb_pkg::REG_SHORT_T)  ? {8'h00, short_time} :
    (i_addr == smdb_pkg::REG_EXT_T)    ? ext_time :
    (i_addr == smdb_pkg::REG_ERR_CNT)  ? err_count :
    (i_addr == smdb_pkg::REG_ERR_IDX)  ? {13'h0000, err_index} :
    val_hit                            ? {8'h00, attr_value[val_idx]} :
                                         16'h0000;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  assign o_busy = (state == SMDB_RUN);

endmodule // smdb_sector_builder

// File: sim/smdb_host_model.sv
// host-side consumer model taking sector bytes
`timescale 1ns/1ps
module smdb_host_model (
  input  wire logic i_clk,    // system clock
  input  wire logic i_arst_n, // async reset, active low
  input  wire logic i_slow,   // stall on a pattern when high
  output logic      o_ready   // takes the offered byte
);
  logic [7:0] lfsr;  // stall pattern
  // ready always when prompt, on a pseudo-random pattern when slow
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lfsr    <= 8'h5a;
      o_ready <= 1'b0;
    end else begin
      lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      o_ready <= !i_slow || lfsr[0];
    end
  end
endmodule // smdb_host_model

// File: sim/smdb_sector_builder_monitor.sv
// assertion checker for the sector builder ports
`timescale 1ns/1ps
module smdb_sector_monitor (
  input wire logic        i_clk,    // system clock
  input wire logic        i_arst_n, // async reset, active low
  input wire logic [7:0]  i_addr,   // register address
  input wire logic [15:0] i_wdata,  // write data
  input wire logic        i_wr,     // write strobe
  input wire logic        i_rd,     // read strobe
  input wire logic [15:0] o_rdata,  // read data
  input wire logic        i_error,  // error pulse
  input wire logic [7:0]  o_data,   // sector byte
  input wire logic        o_valid,  // byte valid
  input wire logic        o_last,   // final byte
  input wire logic        i_ready,  // consumer ready
  input wire logic        o_busy    // transfer running
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [8:0] pos;   // offset of the byte on show
  logic [1:0] kind;  // kind of the running sector
  logic [7:0] sum;   // running byte sum
  // start decode and expected capability bytes
  wire start = i_wr && i_addr == smdb_pkg::REG_CTRL && i_wdata[4];
  wire cap_pos = pos >= 9'h16f && pos <= 9'h172;
  wire [7:0] cap_exp = pos == 9'h16f ? 8'h1b : pos == 9'h170 ? 8'h03 :
                       pos == 9'h172 ? 8'h01 : 8'h00;
  // offset, kind and sum tracking
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos  <= 9'h0;
      sum  <= 8'h0;
      kind <= 2'h0;
    end else begin
      pos  <= !o_busy ? 9'h0 : pos + 9'(o_valid && i_ready);
      sum  <= !o_busy ? 8'h0 : sum + (o_valid && i_ready ? o_data : 8'h0);
      kind <= start && !o_busy ? i_wdata[1:0] : kind;
    end
  end
  sequence s_launch;
    start && !o_busy;
  endsequence
  sequence s_stream_up;
    o_busy ##1 o_valid;
  endsequence
  a_start_stream: assert property (s_launch |=> s_stream_up)
    else $error("sector did not start on time");
  a_byte_hold: assert property (o_valid && !i_ready |=>
    o_valid && $stable(o_data)) else $error("byte changed while stalled");
  a_last_pos: assert property (o_valid |-> o_last == (pos == 9'h1ff))
    else $error("last flag at wrong offset");
  a_cap_fields: assert property (kind == smdb_pkg::SMDB_SEC_VALUES &&
    o_valid && cap_pos |-> o_data == cap_exp)
    else $error("capability byte wrong");
  a_sum_zero: assert property (o_valid && o_last &&
    kind != smdb_pkg::SMDB_SEC_LOGDIR |-> sum + o_data == 8'h0)
    else $error("checksum wrong");
  a_first_byte: assert property (o_valid && pos == 9'h0 |->
    o_data == (kind[1] ? 8'h01 : 8'h10)) else $error("first byte wrong");
  a_dir_vendor: assert property (kind == smdb_pkg::SMDB_SEC_LOGDIR &&
    o_valid && pos >= 9'h100 && pos <= 9'h13f |->
    o_data == (pos[0] ? 8'h00 : 8'h10)) else $error("log length wrong");
  a_err_index: assert property (kind == smdb_pkg::SMDB_SEC_ERRLOG &&
    o_valid && pos == 9'h1 |-> o_data inside {[8'h01:8'h05]})
    else $error("error index out of range");
endmodule // smdb_sector_monitor
bind smdb_sector_builder smdb_sector_monitor i_mon (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_error(i_error), .o_data(o_data),
  .o_valid(o_valid), .o_last(o_last), .i_ready(i_ready), .o_busy(o_busy));

// File: sim/smdb_sector_builder_test.sv
// self-checking bench for the sector builder
`timescale 1ns/1ps
module smdb_sector_builder_test;
  typedef struct packed {logic [8:0] off; logic [7:0] val;} smdb_note_t;
  logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        err = 1'b0, slow = 1'b0, rd_pend = 1'b0;
  logic [7:0]  addr = 8'h0, data, ext;
  logic [15:0] wdata = 16'h0, rdata;
  logic        valid, last, ready, busy;
  logic [8:0]  pos = 9'h0;
  logic [7:0]  sec [512], av [30], tv [15];
  logic [15:0] v [7];
  logic [31:0] rs = 32'd26363;
  smdb_note_t  bq[$], nt;
  logic [15:0] rq[$];
  int          err_count = 0, total_checks = 0, nerr = 0;
  always #25 clk = ~clk;
  smdb_sector_builder i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_error(err),
    .o_data(data), .o_valid(valid), .o_last(last), .i_ready(ready),
    .o_busy(busy));
  smdb_host_model i_host (.i_clk(clk), .i_arst_n(arst_n), .i_slow(slow),
    .o_ready(ready));
  function automatic logic [15:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    access(1'b0, a, 16'h0);
  endtask
  task automatic note(input int off, input logic [7:0] val);
    bq.push_back('{9'(off), val});
  endtask
  task automatic push_sec(input logic with_sum);
    logic [7:0] s = 8'h0;
    for (int i = 0; i < 511; i++) s += sec[i];
    if (with_sum) sec[511] = -s;
    foreach (sec[i]) note(i, sec[i]);
  endtask
  task automatic start(input logic [1:0] kind);
    access(1'b1, smdb_pkg::REG_CTRL, {11'h0, 1'b1, 2'h0, kind});
  endtask
  task automatic finish_run();
    // let the start write land before watching busy
    @(posedge clk);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    @(posedge clk);
    check({15'h0, busy}, 16'h0);
    check(16'(bq.size()), 16'h0);
  endtask
  task automatic errs(input int n);
    @(posedge clk);
    err <= 1'b1;
    repeat (n) @(posedge clk);
    err <= 1'b0;
    nerr += n;
  endtask
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // checks read results in order; takes the oldest notes while their offset matches the accepted byte
  always @(posedge clk) begin
    if (rd_pend) check(rdata, rq.pop_front());
    rd_pend <= rd;
    if (valid === 1'b1 && ready === 1'b1) begin
      while (bq.size() > 0 && bq[0].off == pos) begin
        nt = bq.pop_front();
        check({8'h0, data}, {8'h0, nt.val});
      end
      pos <= last ? 9'h0 : pos + 9'h1;
    end
  end
  // cut a hang short; the run needs some 68000 cycles
  initial begin
    #(50 * 100000);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdx(smdb_pkg::REG_ERR_CNT, 16'h0000);
    rdx(smdb_pkg::REG_ERR_IDX, 16'h0005);
    rdx(8'h20, 16'h0000);
    // values sector with random field and attribute contents, host stalls
    for (int i = 1; i < 7; i++) begin
      v[i] = rnd();
      access(1'b1, 8'(i), v[i]);
    end
    for (int k = 0; k < 30; k++) begin
      av[k] = 8'(rnd());
      access(1'b1, smdb_pkg::REG_VAL_BASE + 8'(k), {8'h0, av[k]});
    end
    rdx(smdb_pkg::REG_COLLECT, v[3]);
    rdx(smdb_pkg::REG_OFF_STAT, {8'h0, v[1][7:0]});
    rdx(smdb_pkg::REG_EXT_T, v[6]);
    rdx(smdb_pkg::REG_VAL_BASE + 8'h1d, {8'h0, av[29]});
    note(0, 8'h10);
    note(1, 8'h00);
    for (int k = 0; k < 30; k++) begin
      if (smdb_pkg::ATTR_ID[k] != 8'h0) begin
        note(2 + 12 * k, smdb_pkg::ATTR_ID[k]);
        note(3 + 12 * k, smdb_pkg::ATTR_FLAGS[7:0]);
        note(4 + 12 * k, smdb_pkg::ATTR_FLAGS[15:8]);
        note(5 + 12 * k, av[k]);
      end
    end
    ext = v[6] > 16'h00fe ? 8'hff : v[6][7:0];
    tv = '{v[1][7:0], v[2][7:0], v[3][7:0], v[3][15:8], 8'h00, 8'h1b,
           8'h03, 8'h00, 8'h01, v[4][7:0], v[5][7:0], ext, 8'h00,
           v[6][7:0], v[6][15:8]};
    for (int j = 0; j < 15; j++) note(12'h16a + j, tv[j]);
    slow <= 1'b1;
    start(smdb_pkg::SMDB_SEC_VALUES);
    finish_run();
    slow <= 1'b0;
    // thresholds sector; host writes and a second start must not disturb it
    access(1'b1, 8'h60, rnd());
    foreach (sec[i]) sec[i] = 8'h0;
    sec[0] = 8'h10;
    for (int k = 0; k < 30; k++) begin
      sec[2 + 12 * k] = smdb_pkg::ATTR_ID[k];
      sec[3 + 12 * k] = smdb_pkg::ATTR_THRESH[k];
    end
    push_sec(1'b1);
    start(smdb_pkg::SMDB_SEC_THRESH);
    rdx(smdb_pkg::REG_CTRL, 16'h0101);
    start(smdb_pkg::SMDB_SEC_LOGDIR);
    finish_run();
    // log directory
    foreach (sec[i]) sec[i] = 8'h0;
    sec[0] = 8'h01;
    for (int a = 1; a < 256; a++)
      sec[2 * a] = a == 1 ? 8'h01 : (a >= 128 && a < 160) ? 8'h10 : 8'h00;
    push_sec(1'b0);
    start(smdb_pkg::SMDB_SEC_LOGDIR);
    finish_run();
    // summary error log after six errors, index wrapped to 1
    errs(6);
    foreach (sec[i]) sec[i] = 8'h0;
    sec[0] = 8'h01;
    sec[1] = 8'(((nerr - 1) % 5) + 1);
    sec[12'h1c4] = 8'(nerr);
    push_sec(1'b1);
    start(smdb_pkg::SMDB_SEC_ERRLOG);
    finish_run();
    // count saturates, index keeps cycling
    errs(65540);
    rdx(smdb_pkg::REG_ERR_CNT, 16'hffff);
    rdx(smdb_pkg::REG_ERR_IDX, 16'(((nerr - 1) % 5) + 1));
    repeat (3) @(posedge clk);
    check(16'(rq.size()), 16'h0);
    give_verdict();
  end
endmodule // smdb_sector_builder_test
